//--- hw/pmd_data_port.sv
/*
 * Controller-facing data port of a 10/100 transceiver: MII, RMII and serial
 * 10 Mb/s modes, clock outputs, transmit sampling into a FIFO, receive drive.
 * Assumes the line side presents receive symbols on ref_clk and drains the
 * transmit FIFO; configuration inputs are quasi-static logic on ref_clk.
 */
// Summary of operation
// - MII transmit clock 25 MHz at 100 Mb/s, 2.5 MHz at 10 Mb/s.
// - RMII leaves clock outputs idle, times both directions from 50 MHz reference.
// - MII and serial transmit data sampled on own transmit clock.
// - RMII two-bit transmit data sampled on the 50 MHz reference.
// - Receive clock 25/2.5 MHz in MII, 10 MHz in serial mode.
// - MII receive valid high exactly while receive nibbles are valid.
// - Receive valid pin straps mode at reset, MII default, undriven serial.
// - RMII receive valid indication independent of carrier sense.
// - MII 100 Mb/s receive error on invalid symbol within a packet.
// - RMII 100 Mb/s receive error on media error with valid; none serial.
// - Receive data corrupted whenever a receive error occurs.
// - MII receive nibbles driven on the receive clock.
// - RMII receive dibits driven on the 50 MHz reference.
// - Serial receive data on bit 0 only, framed by carrier; upper bits unused.
// - MII and serial carrier sense high while medium is non-idle.
// - RMII merged carrier sense and receive valid output.
// - Collision on simultaneous transmit and receive in half duplex, outside RMII.
// - 10 Mb/s half duplex heartbeat outside RMII raises collision for about 1 us right after transmit.
// - Full duplex holds collision low with no heartbeat.
`timescale 1ns/1ns
module pmd_data_port #(
    parameter int FIFO_DEPTH_P = pmd_pkg::FIFO_DEPTH
) (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       serial_ten_meg_mode,
    input  wire logic       cfg_speed_100,
    input  wire logic       cfg_full_duplex,
    input  wire logic       cfg_heartbeat_en,
    output logic [1:0]      mode_active,
    output logic            tx_clk,
    input  wire logic       tx_en,
    input  wire logic [3:0] txd,
    output logic            rx_clk,
    input  wire logic       receive_valid_strap,
    output logic            receive_valid_indication,
    output logic            receive_valid_oe,
    output logic            rx_er,
    output logic [3:0]      rxd,
    output logic            crs,
    output logic            col,
    input  wire logic       line_rx_carrier,
    input  wire logic       line_rx_dv,
    input  wire logic [3:0] line_rx_data,
    input  wire logic       line_rx_err,
    output logic            line_rx_take,
    output logic            line_tx_valid,
    output logic            line_tx_en,
    output logic [3:0]      line_tx_data,
    input  wire logic       line_tx_ready,
    input  wire logic       tx_overrun_clr,
    output logic            tx_overrun
);
    import pmd_pkg::*;

    if (FIFO_DEPTH_P < 2) begin : g_bad_depth
        $error("pmd_data_port FIFO depth too small");
    end

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic              tx_en_m;
        logic              tx_en_s;
        logic [3:0]        txd_m;
        logic [3:0]        txd_s;
        logic              strap_m;
        logic              strap_s;
        logic [1:0]        strap_cnt;
        logic              strap_done;
        logic              strap_val;
        pmd_mode_t         mode;
        logic              speed100;
        logic              full_dup;
        logic              hb_en;
        logic [DIV_W-1:0]  div_cnt;
        logic              clk_ph;
        logic              tx_clk;
        logic              rx_clk;
        logic              tx_act;
        logic [SQE_W-1:0]  sqe_cnt;
        logic              col;
        logic              push_v;
        logic [FIFO_W-1:0] push_d;
        logic              overrun;
        logic              rx_dv;
        logic              rx_dv_oe;
        logic              rx_er;
        logic [3:0]        rxd;
        logic              crs;
        logic              take;
    } pmd_state_t;

    pmd_state_t        s;
    pmd_state_t        next_s;
    logic [DIV_W-1:0]  half;
    logic              tick_edge;
    logic              tick_rise;
    logic              tick_fall;
    logic              idle;
    logic              spd10;
    logic              fifo_in_ready;
    logic [FIFO_W-1:0] fifo_out_data;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [DIV_W-1:0] half_of(input pmd_mode_t m, input logic fast);
        if (m == MODE_RMII) begin
            return HALF_RMII;
        end else if (m == MODE_SER) begin
            return HALF_SER;
        end else if (fast) begin
            return HALF_MII100;
        end else begin
            return HALF_MII10;
        end
    endfunction

    function automatic logic [3:0] lane_mask(input pmd_mode_t m);
        if (m == MODE_RMII) begin
            return MASK_RMII;
        end else if (m == MODE_SER) begin
            return MASK_SER;
        end else begin
            return MASK_MII;
        end
    endfunction

    function automatic pmd_mode_t mode_sel(input logic ser, input logic strap);
        if (ser) begin
            return MODE_SER;
        end else if (strap == STRAP_RMII) begin
            return MODE_RMII;
        end else begin
            return MODE_MII;
        end
    endfunction

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb begin
        next_s         = s;
        next_s.tx_en_m = tx_en;
        next_s.tx_en_s = s.tx_en_m;
        next_s.txd_m   = txd;
        next_s.txd_s   = s.txd_m;
        next_s.strap_m = receive_valid_strap;
        next_s.strap_s = s.strap_m;
        next_s.push_v  = 1'b0;
        next_s.take    = 1'b0;

        // Strap caught once the synchroniser has filled after release
        if (!s.strap_done) begin
            if (s.strap_cnt == STRAP_WAIT) begin
                next_s.strap_done = 1'b1;
                next_s.strap_val  = s.strap_s;
                next_s.mode       = mode_sel(serial_ten_meg_mode, s.strap_s);
                next_s.speed100   = cfg_speed_100;
                next_s.full_dup   = cfg_full_duplex;
                next_s.hb_en      = cfg_heartbeat_en;
            end else begin
                next_s.strap_cnt = s.strap_cnt + 2'h1;
            end
        end

        // Clock divider, one half period per phase
        half      = half_of(s.mode, s.speed100);
        tick_edge = s.div_cnt >= (half - DIV_W'(1));
        tick_rise = tick_edge && !s.clk_ph;
        tick_fall = tick_edge && s.clk_ph;
        if (tick_edge) begin
            next_s.div_cnt = '0;
            next_s.clk_ph  = !s.clk_ph;
        end else begin
            next_s.div_cnt = s.div_cnt + DIV_W'(1);
        end

        // Settings change only between frames, at a low-going edge
        idle = !s.tx_en_s && !s.tx_act && !line_rx_carrier && (s.sqe_cnt == '0);
        if (s.strap_done && tick_fall && idle) begin
            next_s.mode     = mode_sel(serial_ten_meg_mode, s.strap_val);
            next_s.speed100 = cfg_speed_100;
            next_s.full_dup = cfg_full_duplex;
            next_s.hb_en    = cfg_heartbeat_en;
        end
        next_s.tx_clk = (s.mode != MODE_RMII) && next_s.clk_ph;
        next_s.rx_clk = (s.mode != MODE_RMII) && next_s.clk_ph;

        // Transmit sampling and heartbeat
        spd10 = (s.mode == MODE_SER) || !s.speed100;
        if (s.sqe_cnt != '0) begin
            next_s.sqe_cnt = s.sqe_cnt - SQE_W'(1);
        end
        if (tick_rise) begin
            if (s.tx_en_s) begin
                next_s.push_v = 1'b1;
                next_s.push_d = {1'b1, s.txd_s & lane_mask(s.mode)};
            end else if (s.tx_act) begin
                next_s.push_v = 1'b1;
                next_s.push_d = '0;
                if (spd10 && !s.full_dup && s.hb_en && s.mode != MODE_RMII) begin
                    next_s.sqe_cnt = SQE_CYC;
                end
            end
            next_s.tx_act = s.tx_en_s;
        end
        if (tx_overrun_clr) begin
            next_s.overrun = 1'b0;
        end
        if (s.push_v && !fifo_in_ready) begin
            next_s.overrun = 1'b1;
        end
        next_s.col = !s.full_dup && (s.mode != MODE_RMII)
            && ((s.tx_act && line_rx_carrier) || (s.sqe_cnt != '0));

        // Receive drive on the low-going edge of the receive clock
        if (tick_fall) begin
            next_s.take = 1'b1;
            case (s.mode)
                MODE_MII: begin
                    next_s.rx_dv = line_rx_dv;
                    next_s.rxd   = line_rx_err ? CORRUPT_NIB : line_rx_data;
                    next_s.rx_er = s.speed100 && line_rx_dv && line_rx_err;
                    next_s.crs   = line_rx_carrier;
                end
                MODE_RMII: begin
                    next_s.rx_dv = line_rx_dv;
                    next_s.rxd   = {2'h0, line_rx_err ? CORRUPT_NIB[1:0] : line_rx_data[1:0]};
                    next_s.rx_er = s.speed100 && line_rx_dv && line_rx_err;
                    next_s.crs   = line_rx_carrier || line_rx_dv;
                end
                default: begin
                    next_s.rx_dv = 1'b0;
                    next_s.rxd   = {3'h0, line_rx_carrier && (line_rx_data[0] ^ line_rx_err)};
                    next_s.rx_er = 1'b0;
                    next_s.crs   = line_rx_carrier;
                end
            endcase
        end
        next_s.rx_dv_oe = s.strap_done && (s.mode != MODE_SER);
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // ****************************************************************
    // Transmit FIFO toward the line
    // ****************************************************************
    pmd_fifo #(
        .WIDTH (FIFO_W),
        .DEPTH (FIFO_DEPTH_P)
    ) u_tx_fifo (
        .clk       (ref_clk),
        .rst       (rst),
        .in_valid  (s.push_v),
        .in_data   (s.push_d),
        .in_ready  (fifo_in_ready),
        .out_valid (line_tx_valid),
        .out_data  (fifo_out_data),
        .out_ready (line_tx_ready)
    );

    assign line_tx_en               = fifo_out_data[FIFO_W-1];
    assign line_tx_data             = fifo_out_data[3:0];
    assign mode_active              = s.mode;
    assign tx_clk                   = s.tx_clk;
    assign rx_clk                   = s.rx_clk;
    assign receive_valid_indication = s.rx_dv;
    assign receive_valid_oe         = s.rx_dv_oe;
    assign rx_er                    = s.rx_er;
    assign rxd                      = s.rxd;
    assign crs                      = s.crs;
    assign col                      = s.col;
    assign line_rx_take             = s.take;
    assign tx_overrun               = s.overrun;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence mii100_high;
        tx_clk [*2] ##1 !tx_clk;
    endsequence

    sequence ser_high;
        tx_clk [*5] ##1 !tx_clk;
    endsequence

    sequence tx_frame_end;
        tick_rise && !s.tx_en_s && s.tx_act;
    endsequence

    tx_clk_fast_a: assert property (
        $rose(tx_clk) && s.mode == MODE_MII && s.speed100 |-> mii100_high)
        else $error("fast transmit clock high phase wrong");
    ser_clk_a: assert property (
        $rose(rx_clk) && s.mode == MODE_SER |-> rx_clk [*5] ##1 !rx_clk)
        else $error("serial receive clock high phase wrong");
    ser_tx_clk_a: assert property (
        $rose(tx_clk) && s.mode == MODE_SER |-> ser_high)
        else $error("serial transmit clock high phase wrong");
    rmii_clk_off_a: assert property (
        s.mode == MODE_RMII && $past(s.mode) == MODE_RMII |-> !tx_clk && !rx_clk)
        else $error("clock output active in reduced mode");
    tx_sample_a: assert property (
        tick_rise && s.tx_en_s |=> s.push_v && s.push_d[FIFO_W-1]
            && ((s.push_d[3:0] & ~lane_mask(s.mode)) == 4'h0))
        else $error("transmit symbol not captured");
    sqe_start_a: assert property (
        tx_frame_end ##0 (spd10 && !s.full_dup && s.hb_en && s.mode != MODE_RMII)
            |=> s.sqe_cnt == SQE_CYC ##1 col)
        else $error("heartbeat not started");
    sqe_stop_a: assert property (
        s.sqe_cnt == SQE_W'(1) && !tick_rise |=> s.sqe_cnt == '0)
        else $error("heartbeat length wrong");
    fdx_col_a: assert property (
        s.full_dup && $past(s.full_dup) |-> !col && s.sqe_cnt == '0)
        else $error("collision in full duplex");
    col_detect_a: assert property (
        !s.full_dup && s.mode != MODE_RMII && s.tx_act && line_rx_carrier |=> col)
        else $error("collision missed");
    rx_corrupt_a: assert property (
        tick_fall && s.mode == MODE_MII && line_rx_err |=> rxd == CORRUPT_NIB)
        else $error("errored nibble not corrupted");
    rx_err_a: assert property (
        tick_fall && s.mode != MODE_SER && s.speed100 && line_rx_dv && line_rx_err |=> rx_er)
        else $error("receive error not raised");
    rmii_crsdv_a: assert property (
        tick_fall && s.mode == MODE_RMII |=> crs == $past(line_rx_carrier || line_rx_dv))
        else $error("merged carrier wrong");
    ser_rx_a: assert property (
        s.mode == MODE_SER && $past(s.mode) == MODE_SER |=> rxd[3:1] == 3'h0
            && !receive_valid_oe && !rx_er)
        else $error("serial receive lanes wrong");
    strap_mode_a: assert property (
        $rose(s.strap_done) && !$past(serial_ten_meg_mode)
            |-> (s.mode == MODE_RMII) == (s.strap_val == STRAP_RMII))
        else $error("strapped mode wrong");

endmodule // pmd_data_port

//--- hw/pmd_pkg.sv
/*
 * Shared constants and types for the controller-facing data port of a
 * 10/100 Ethernet transceiver: clock ratios, frame-edge timing, lane masks.
 * Assumes a single 100 MHz system clock that also stands for the reference.
 */
package pmd_pkg;

    // ****************************************************************
    // Clock rates and derived divider counts
    // ****************************************************************
    localparam int CLK_HZ     = 100_000_000;
    localparam int MII100_HZ  = 25_000_000;
    localparam int MII10_HZ   = 2_500_000;
    localparam int SER_HZ     = 10_000_000;
    localparam int RMII_HZ    = 50_000_000;
    localparam int DIV_W      = 5;

    localparam logic [DIV_W-1:0] HALF_MII100 = DIV_W'(CLK_HZ / (2 * MII100_HZ));
    localparam logic [DIV_W-1:0] HALF_MII10  = DIV_W'(CLK_HZ / (2 * MII10_HZ));
    localparam logic [DIV_W-1:0] HALF_SER    = DIV_W'(CLK_HZ / (2 * SER_HZ));
    localparam logic [DIV_W-1:0] HALF_RMII   = DIV_W'(CLK_HZ / (2 * RMII_HZ));

    // ****************************************************************
    // Heartbeat pulse length
    // ****************************************************************
    localparam int SQE_NS = 1000;
    localparam int SQE_W  = 7;
    localparam logic [SQE_W-1:0] SQE_CYC = SQE_W'((SQE_NS * (CLK_HZ / 1_000_000)) / 1000);

    // ****************************************************************
    // Strap capture and data path
    // ****************************************************************
    localparam logic [1:0] STRAP_WAIT  = 2'h2;
    localparam logic       STRAP_RMII  = 1'h1;
    localparam logic [3:0] CORRUPT_NIB = 4'he;
    localparam logic [3:0] MASK_MII    = 4'hf;
    localparam logic [3:0] MASK_RMII   = 4'h3;
    localparam logic [3:0] MASK_SER    = 4'h1;
    localparam int         FIFO_W      = 5;
    localparam int         FIFO_DEPTH  = 32;

    typedef enum logic [1:0] {
        MODE_MII,
        MODE_RMII,
        MODE_SER
    } pmd_mode_t;

endpackage

//--- hw/pmd_fifo.sv
/*
 * Synchronous FIFO with valid/ready on both sides and registered read data.
 * Assumes one clock and an asynchronous active-high reset; depth a power of two.
 */
`timescale 1ns/1ns
module pmd_fifo #(
    parameter int WIDTH = 5,
    parameter int DEPTH = 32
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    output logic                  out_valid,
    output logic      [WIDTH-1:0] out_data,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("pmd_fifo depth must be a power of two of at least 2");
    end

    typedef struct packed {
        logic [AW-1:0]    wr_ptr;
        logic [AW-1:0]    rd_ptr;
        logic [AW:0]      count;
        logic             out_valid;
        logic [WIDTH-1:0] out_data;
    } pmd_fifo_state_t;

    pmd_fifo_state_t   s;
    pmd_fifo_state_t   next_s;
    logic [WIDTH-1:0]  mem [DEPTH];
    logic              push;
    logic              load;

    assign in_ready  = s.count != (AW+1)'(DEPTH);
    assign out_valid = s.out_valid;
    assign out_data  = s.out_data;

    always_comb begin
        next_s = s;
        push   = in_valid && in_ready;
        load   = (s.count != '0) && (!s.out_valid || out_ready);
        if (push) begin
            next_s.wr_ptr = s.wr_ptr + AW'(1);
        end
        if (load) begin
            next_s.out_data  = mem[s.rd_ptr];
            next_s.out_valid = 1'b1;
            next_s.rd_ptr    = s.rd_ptr + AW'(1);
        end else if (out_ready) begin
            next_s.out_valid = 1'b0;
        end
        next_s.count = s.count + (AW+1)'(push) - (AW+1)'(load);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // Storage carries no reset
    always_ff @(posedge clk) begin
        if (push) begin
            mem[s.wr_ptr] <= in_data;
        end
    end

endmodule // pmd_fifo

//--- dv/pmd_mac_model.sv
/*
 * Controller-side transmit model: sends frames of counting nibbles on tx_clk.
 * Assumes tx_clk comes from the data port and the bench pulses start.
 */
`timescale 1ns/1ns
module pmd_mac_model (
    input  wire logic       tx_clk,
    input  wire logic       crs,
    input  wire logic       start,
    input  wire logic [7:0] len,
    output logic            tx_en,
    output logic [3:0]      txd,
    output logic            busy,
    output logic            mac_col
);
    // Merged carrier with own enable
    assign mac_col = crs & tx_en;
    initial begin
        tx_en = 1'h0;
        txd   = 4'h5;
        busy  = 1'h0;
        forever begin
            @(posedge start);
            busy = 1'h1;
            for (int i = 0; i < len; i++) begin
                @(posedge tx_clk);
                #1;
                tx_en = 1'h1;
                txd   = 4'(i + 1);
            end
            @(posedge tx_clk);
            #1;
            tx_en = 1'h0;
            txd   = ~txd;
            busy  = 1'h0;
        end
    end
endmodule // pmd_mac_model

//--- dv/tb_pmd_data_port.sv
/*
 * Self-checking bench: receive table per mode, clocks, transmit path,
 * collision, heartbeat, FIFO overrun. Assumes pmd_pkg and pmd_mac_model.
 */
`timescale 1ns/1ns
module tb_pmd_data_port;
    import pmd_pkg::*;
    logic       ref_clk = 1'h0, rst = 1'h1, ser = 1'h0, spd = 1'h1, fdx = 1'h1, hb = 1'h0;
    logic       strap = 1'h0, rx_car = 1'h0, rx_dv = 1'h0, rx_err = 1'h0, tx_rdy = 1'h1;
    logic       ov_clr = 1'h0, start = 1'h0, tx_en, tx_clk, rx_clk, rv, rv_oe, rx_er, crs;
    logic       col, take, ltv, lte, busy, ov, mcol;
    logic [3:0] txd, rxd, ltd, rx_dat = 4'h0;
    logic [1:0] mode;
    logic [7:0] len = 8'h10;
    logic [4:0] got [$];
    int         num_errors = 0, n_checks = 0, cyc = 0, ncol = 0, nmcol = 0;
    // Mode, line {carrier,dv,data,err}, expected {rxd,rx_er,crs,valid}
    logic [15:0] rows [9] = '{16'h352b, 16'h3af7, 16'h231a, 16'h0000, 16'h571b,
                              16'h7597, 16'ha10a, 16'hb182, 16'h8100};
    always #5 ref_clk = ~ref_clk;
    pmd_data_port DUT (
        .ref_clk(ref_clk), .rst(rst), .serial_ten_meg_mode(ser), .cfg_speed_100(spd),
        .cfg_full_duplex(fdx), .cfg_heartbeat_en(hb), .mode_active(mode), .tx_clk(tx_clk),
        .tx_en(tx_en), .txd(txd), .rx_clk(rx_clk), .receive_valid_strap(strap),
        .receive_valid_indication(rv), .receive_valid_oe(rv_oe), .rx_er(rx_er), .rxd(rxd),
        .crs(crs), .col(col), .line_rx_carrier(rx_car), .line_rx_dv(rx_dv),
        .line_rx_data(rx_dat), .line_rx_err(rx_err), .line_rx_take(take),
        .line_tx_valid(ltv), .line_tx_en(lte), .line_tx_data(ltd), .line_tx_ready(tx_rdy),
        .tx_overrun_clr(ov_clr), .tx_overrun(ov)
    );
    pmd_mac_model MAC (
        .tx_clk(tx_clk), .crs(crs), .start(start), .len(len), .tx_en(tx_en), .txd(txd),
        .busy(busy), .mac_col(mcol)
    );
    task automatic print_verdict();
        if (num_errors == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (ltv === 1'h1 && tx_rdy)
            got.push_back({lte, ltd});
        if (col === 1'h1)
            ncol++;
        if (mcol === 1'h1)
            nmcol++;
        if (cyc == 60000) begin
            num_errors++;
            print_verdict();
        end
    end
    task automatic cmp(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic do_reset(input logic [1:0] md, input logic s, input logic f, input logic h);
        rst = 1'h1;
        ser = (md == 2'h2);
        strap = (md == 2'h1);
        spd = s;
        fdx = f;
        hb = h;
        tick(5);
        rst = 1'h0;
        tick(8);
    endtask
    task automatic wait_take();
        for (int i = 0; i < 60; i++) begin
            tick(1);
            if (take === 1'h1)
                return;
        end
        cmp({7'h0, take}, 8'h1);
    endtask
    task automatic clk_per(input logic [7:0] p);
        int n;
        n = 0;
        for (int ph = 0; ph < 4; ph++) begin
            if (ph == 2)
                n = 0;
            while (tx_clk !== ph[0] && n < 300) begin
                tick(1);
                n++;
            end
        end
        cmp(8'(n), p);
        cmp({7'h0, rx_clk}, 8'h1);
    endtask
    task automatic send(input logic [7:0] n);
        len = n;
        start = 1'h1;
        tick(1);
        start = 1'h0;
        for (int i = 0; i < 3000 && (busy === 1'h1 || i < 2); i++)
            tick(1);
        tick(20);
    endtask
    initial begin
        logic [1:0] md;
        md = 2'h3;
        for (int r = 0; r < 9; r++) begin
            if (rows[r][15:14] != md) begin
                md = rows[r][15:14];
                do_reset(md, 1'h1, 1'h1, 1'h0);
                cmp({6'h0, mode}, {6'h0, md});
                cmp({7'h0, rv_oe}, {7'h0, md != 2'h2});
                if (md != 2'h1)
                    clk_per(md == 2'h0 ? 8'h4 : 8'ha);
                for (int i = 0; i < 20 && md == 2'h1; i++) begin
                    tick(1);
                    cmp({6'h0, tx_clk, rx_clk}, 8'h0);
                end
            end
            wait_take();
            {rx_car, rx_dv, rx_dat, rx_err} = rows[r][13:7];
            wait_take();
            cmp({1'h0, rxd, rx_er, crs, rv}, {1'h0, rows[r][6:0]});
        end
        // Frame of 20 nibbles, then collision with carrier in half duplex
        do_reset(2'h0, 1'h1, 1'h0, 1'h0);
        got.delete();
        send(8'h14);
        cmp(8'(got.size()), 8'h15);
        for (int i = 0; i < 20; i++)
            cmp({3'h0, got[i]}, {3'h0, 1'h1, 4'(i + 1)});
        cmp({3'h0, got[20]}, 8'h0);
        rx_car = 1'h1;
        ncol = 0;
        nmcol = 0;
        send(8'h4);
        cmp({7'h0, ncol > 0}, 8'h1);
        cmp({7'h0, nmcol > 0}, 8'h1);
        rx_car = 1'h0;
        // Heartbeat only in 10 Mb/s half duplex
        do_reset(2'h0, 1'h0, 1'h0, 1'h1);
        clk_per(8'h28);
        ncol = 0;
        send(8'h2);
        tick(150);
        cmp({7'h0, ncol >= 90 && ncol <= 110}, 8'h1);
        do_reset(2'h0, 1'h0, 1'h1, 1'h1);
        rx_car = 1'h1;
        ncol = 0;
        send(8'h2);
        tick(150);
        cmp(8'(ncol), 8'h0);
        rx_car = 1'h0;
        // Serial frame: only bit 0 of each symbol travels
        do_reset(2'h2, 1'h1, 1'h1, 1'h0);
        got.delete();
        send(8'h3);
        cmp(8'(got.size()), 8'h4);
        for (int i = 0; i < 3; i++)
            cmp({3'h0, got[i]}, {3'h0, 1'h1, 3'h0, 1'(i + 1)});
        cmp({3'h0, got[3]}, 8'h0);
        // Stalled drain overflows the FIFO
        do_reset(2'h0, 1'h1, 1'h1, 1'h0);
        tx_rdy = 1'h0;
        send(8'h28);
        cmp({7'h0, ov}, 8'h1);
        ov_clr = 1'h1;
        tick(1);
        ov_clr = 1'h0;
        tick(2);
        cmp({7'h0, ov}, 8'h0);
        got.delete();
        tx_rdy = 1'h1;
        tick(150);
        cmp({3'h0, got[0]}, 8'h11);
        cmp({7'h0, ltv}, 8'h0);
        print_verdict();
    end
endmodule // tb_pmd_data_port
